// ---- sdf_pkg.sv ----
package sdf_pkg;
   // Master clock division figures
   localparam int MOD_DIV = 512;
   localparam int SAMP_DIV = 256;
   localparam int MAX_OVERSAMPLE = 8;
   // Decimation ratio limits, one output per code modulator samples
   localparam logic [11:0] NOTCH_CODE_MIN = 12'h013;
   localparam logic [11:0] NOTCH_CODE_MAX = 12'h7d0;
   localparam logic [11:0] NOTCH_CODE_RST = 12'h7d0;
   // Output periods to wait after a change of setting
   localparam logic [2:0] SETTLE_PERIODS = 3'h4;
   // Filter word: 3 x log2(2000) bits plus sign plus overrange margin
   localparam int FILT_W = 36;
   localparam int FIFO_DEPTH = 8;
   localparam logic [2:0] GAIN_CODE_RST = 3'h0;

   typedef enum logic [1:0] {
      SDF_GAIN_X1,
      SDF_GAIN_X2,
      SDF_GAIN_X4,
      SDF_GAIN_X8
   } sdf_oversample_t;

   typedef enum {
      SDF_SETTLING,
      SDF_SETTLED
   } sdf_settle_state_t;

   typedef struct packed {
      logic settled;
      logic signed [FILT_W-1:0] word;
   } sdf_result_t;

   typedef struct packed {
      logic [11:0] notch_code;
      logic [2:0] gain_code;
      logic channel;
   } sdf_config_t;
endpackage : sdf_pkg

// ---- sdf_filter.sv ----
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module sdf_fifo #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("sdf_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic full_q, full_d;
   logic push, pop;

   assign in_ready = !full_q;
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];

   always_comb begin
      push = in_valid && !full_q;
      pop = out_valid && out_ready;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      full_d = cnt_d == DEPTH_C;
   end

   always_ff @(posedge clk) begin
      mem_q <= mem_d;
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
      end
   end
endmodule : sdf_fifo

////////////////////////////////////////////////////////////////////////////////
module sdf_filter #(
   parameter int WORD_W = sdf_pkg::FILT_W,
   parameter int DEPTH = sdf_pkg::FIFO_DEPTH
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic MOD_BIT,
   input wire sdf_pkg::sdf_config_t CONFIG,
   input wire logic OUT_READY,
   output logic MOD_TICK,
   output logic SAMPLE_STROBE,
   output logic [2:0] CAP_RATIO,
   output sdf_pkg::sdf_result_t OUT_RESULT,
   output logic OUT_STROBE,
   output logic FIFO_FULL,
   output logic RESULT_LOST
);
   import sdf_pkg::*;

   if (WORD_W != FILT_W) begin : g_chk
      $error("sdf_filter word width must match the package result type");
   end

   localparam int RW = $bits(sdf_result_t);

   // Oversampling factor for each gain code, capped at 8
   function automatic sdf_oversample_t oversample(input logic [2:0] gain);
      case (gain)
         3'h0: oversample = SDF_GAIN_X1;
         3'h1: oversample = SDF_GAIN_X2;
         3'h2: oversample = SDF_GAIN_X4;
         default: oversample = SDF_GAIN_X8;
      endcase
   endfunction : oversample

   function automatic logic [11:0] clamp_code(input logic [11:0] code);
      if (code < NOTCH_CODE_MIN) begin
         clamp_code = NOTCH_CODE_MIN;
      end else if (code > NOTCH_CODE_MAX) begin
         clamp_code = NOTCH_CODE_MAX;
      end else begin
         clamp_code = code;
      end
   endfunction : clamp_code

   //////////////////////////////////////////////////////////////////////////////
   // Input synchroniser for the modulator bitstream
   logic bit_meta_q, bit_sync_q;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         bit_meta_q <= 1'b0;
         bit_sync_q <= 1'b0;
      end else begin
         bit_meta_q <= MOD_BIT;
         bit_sync_q <= bit_meta_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Modulator and input sampling timebase
   localparam logic [8:0] MOD_LAST = 9'(MOD_DIV - 1);
   logic [8:0] phase_q, phase_d;
   logic mod_tick_q, mod_tick_d;
   logic samp_q, samp_d;
   logic [2:0] cap_q, cap_d;
   logic [8:0] samp_mask;

   always_comb begin
      phase_d = (phase_q == MOD_LAST) ? '0 : phase_q + 1'b1;
      mod_tick_d = phase_q == MOD_LAST;
      case (oversample(CONFIG.gain_code))
         SDF_GAIN_X1: samp_mask = 9'(SAMP_DIV - 1);
         SDF_GAIN_X2: samp_mask = 9'(SAMP_DIV / 2 - 1);
         SDF_GAIN_X4: samp_mask = 9'(SAMP_DIV / 4 - 1);
         default: samp_mask = 9'(SAMP_DIV / MAX_OVERSAMPLE - 1);
      endcase
      samp_d = (phase_q & samp_mask) == samp_mask;
      cap_d = CONFIG.gain_code;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         phase_q <= '0;
         mod_tick_q <= 1'b0;
         samp_q <= 1'b0;
         cap_q <= GAIN_CODE_RST;
      end else begin
         phase_q <= phase_d;
         mod_tick_q <= mod_tick_d;
         samp_q <= samp_d;
         cap_q <= cap_d;
      end
   end

   assign MOD_TICK = mod_tick_q;
   assign SAMPLE_STROBE = samp_q;
   assign CAP_RATIO = cap_q;

   //////////////////////////////////////////////////////////////////////////////
   // Sinc3 decimator: three integrators at modulator rate, three combs at
   // output rate; wrap-around arithmetic is exact as long as the word holds
   // code cubed with margin, so overrange never saturates
   logic signed [WORD_W-1:0] int1_q, int2_q, int3_q, int1_d, int2_d, int3_d;
   logic signed [WORD_W-1:0] dly1_q, dly2_q, dly3_q, dly1_d, dly2_d, dly3_d;
   logic signed [WORD_W-1:0] c1, c2, c3;
   logic [11:0] dec_cnt_q, dec_cnt_d, code_q, code_d;
   logic res_valid_q, res_valid_d;
   sdf_result_t res_q, res_d;
   logic signed [WORD_W-1:0] in_val;
   logic fifo_ready;

   // Settling tracker
   sdf_settle_state_t settle_q, settle_d;
   logic [2:0] periods_q, periods_d;
   sdf_config_t cfg_q, cfg_d;
   logic cfg_change;

   always_comb begin
      in_val = bit_sync_q ? WORD_W'(1) : -WORD_W'(1);
      int1_d = int1_q;
      int2_d = int2_q;
      int3_d = int3_q;
      dly1_d = dly1_q;
      dly2_d = dly2_q;
      dly3_d = dly3_q;
      dec_cnt_d = dec_cnt_q;
      code_d = code_q;
      res_valid_d = 1'b0;
      res_d = res_q;
      c1 = int3_q - dly1_q;
      c2 = c1 - dly2_q;
      c3 = c2 - dly3_q;
      if (mod_tick_q) begin
         int1_d = int1_q + in_val;
         int2_d = int2_q + int1_q;
         int3_d = int3_q + int2_q;
         if (dec_cnt_q >= code_q - 1'b1) begin
            // Decimate by the programmed code; notch = modulator rate / code
            dec_cnt_d = '0;
            code_d = clamp_code(CONFIG.notch_code);
            dly1_d = int3_q;
            dly2_d = c1;
            dly3_d = c2;
            res_valid_d = 1'b1;
            res_d.word = c3;
            res_d.settled = settle_q == SDF_SETTLED;
         end else begin
            dec_cnt_d = dec_cnt_q + 1'b1;
         end
      end
      // A new code restarts decimation instead of finishing a long old ratio
      if (CONFIG.notch_code != cfg_q.notch_code) begin
         dec_cnt_d = '0;
         code_d = clamp_code(CONFIG.notch_code);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         int1_q <= '0;
         int2_q <= '0;
         int3_q <= '0;
         dly1_q <= '0;
         dly2_q <= '0;
         dly3_q <= '0;
         dec_cnt_q <= '0;
         code_q <= NOTCH_CODE_RST;
         res_valid_q <= 1'b0;
         res_q <= '0;
      end else begin
         int1_q <= int1_d;
         int2_q <= int2_d;
         int3_q <= int3_d;
         dly1_q <= dly1_d;
         dly2_q <= dly2_d;
         dly3_q <= dly3_d;
         dec_cnt_q <= dec_cnt_d;
         code_q <= code_d;
         res_valid_q <= res_valid_d;
         res_q <= res_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Settling: any change of gain, code or channel restarts the count
   always_comb begin
      cfg_d = CONFIG;
      cfg_change = CONFIG != cfg_q;
      settle_d = settle_q;
      periods_d = periods_q;
      case (settle_q)
         SDF_SETTLING: begin
            if (res_valid_q) begin
               periods_d = periods_q + 1'b1;
               if (periods_q == SETTLE_PERIODS - 1'b1) begin
                  settle_d = SDF_SETTLED;
               end
            end
         end
         SDF_SETTLED: begin
         end
         default: settle_d = SDF_SETTLING;
      endcase
      if (cfg_change) begin
         // A channel switch needs a full settling time as well
         settle_d = SDF_SETTLING;
         periods_d = '0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         settle_q <= SDF_SETTLING;
         periods_q <= '0;
         cfg_q <= '{notch_code: NOTCH_CODE_RST, gain_code: GAIN_CODE_RST, channel: 1'b0};
      end else begin
         settle_q <= settle_d;
         periods_q <= periods_d;
         cfg_q <= cfg_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Result buffer and output register
   logic [RW-1:0] fifo_out;
   logic fifo_valid;
   logic pop;
   sdf_result_t out_q, out_d;
   logic strobe_q, strobe_d;
   logic full_q, full_d;
   logic lost_q, lost_d;

   sdf_fifo #(
      .WIDTH(RW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(CLK),
      .reset(RESET),
      .in_data(res_q),
      .in_valid(res_valid_q),
      .in_ready(fifo_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(pop)
   );

   always_comb begin
      pop = fifo_valid && OUT_READY;
      out_d = out_q;
      strobe_d = pop;
      if (pop) begin
         out_d = sdf_result_t'(fifo_out);
      end
      full_d = !fifo_ready;
      // Sticky mark of a result dropped because the buffer was full
      lost_d = lost_q || (res_valid_q && !fifo_ready);
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         out_q <= '0;
         strobe_q <= 1'b0;
         full_q <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         out_q <= out_d;
         strobe_q <= strobe_d;
         full_q <= full_d;
         lost_q <= lost_d;
      end
   end

   assign OUT_RESULT = out_q;
   assign OUT_STROBE = strobe_q;
   assign FIFO_FULL = full_q;
   assign RESULT_LOST = lost_q;
endmodule : sdf_filter

// ---- sdf_mod_model.sv ----
`timescale 1ns/1ns
module sdf_mod_model (
   input wire logic clk,
   input wire logic level,
   input wire logic mod_tick,
   output logic mod_bit
);
   // One decision per modulator period, held in between
   initial mod_bit = 1'b1;
   always @(posedge clk) begin
      if (mod_tick === 1'b1) begin
         mod_bit <= level;
      end
   end
endmodule : sdf_mod_model

// ---- sdf_properties.sv ----
`timescale 1ns/1ns
module sdf_checker (
   input wire logic CLK,
   input wire logic RESET,
   input wire sdf_pkg::sdf_config_t CONFIG,
   input wire logic OUT_READY,
   input wire logic MOD_TICK,
   input wire logic SAMPLE_STROBE,
   input wire logic [2:0] CAP_RATIO,
   input wire sdf_pkg::sdf_result_t OUT_RESULT,
   input wire logic OUT_STROBE,
   input wire logic FIFO_FULL,
   input wire logic RESULT_LOST
);
   import sdf_pkg::*;
   logic [9:0] gap_q;
   logic [9:0] gap_d;
   // Starts one below zero so the first period reads like the rest
   always_comb begin
      gap_d = gap_q + 10'h1;
      if (RESET) gap_d = 10'h3ff;
      else if (MOD_TICK) gap_d = 10'h0;
   end
   always_ff @(posedge CLK) begin
      gap_q <= gap_d;
   end
   ////////////////////////////////////////
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   property p_tick;
      MOD_TICK == (gap_q == 10'h1ff);
   endproperty
   a_tick: assert property (p_tick) else $error("tick period");
   property p_samp;
      SAMPLE_STROBE && CAP_RATIO >= 3'h3 |-> ##32 SAMPLE_STROBE;
   endproperty
   a_samp: assert property (p_samp) else $error("sample period");
   property p_cap;
      !RESET |=> CAP_RATIO == $past(CONFIG.gain_code);
   endproperty
   a_cap: assert property (p_cap) else $error("cap ratio");
   property p_hold;
      !OUT_STROBE |-> $stable(OUT_RESULT);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_rdy;
      OUT_STROBE |-> $past(OUT_READY);
   endproperty
   a_rdy: assert property (p_rdy) else $error("strobe without ready");
   property p_lost;
      RESULT_LOST |=> RESULT_LOST;
   endproperty
   a_lost: assert property (p_lost) else $error("lost flag cleared");
   property p_drop;
      $rose(RESULT_LOST) |-> FIFO_FULL;
   endproperty
   a_drop: assert property (p_drop) else $error("drop while not full");
   property p_full;
      FIFO_FULL && !OUT_READY |=> FIFO_FULL;
   endproperty
   a_full: assert property (p_full) else $error("full flag fell");
endmodule : sdf_checker

bind sdf_filter sdf_checker sdf_checker_i (.CLK, .RESET, .CONFIG, .OUT_READY, .MOD_TICK,
   .SAMPLE_STROBE, .CAP_RATIO, .OUT_RESULT, .OUT_STROBE, .FIFO_FULL, .RESULT_LOST);

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   import sdf_pkg::*;
   logic clk, reset, level, out_ready, mod_bit;
   logic mod_tick, sample_strobe, out_strobe, fifo_full, result_lost;
   logic [2:0] cap_ratio;
   sdf_config_t cfg;
   sdf_result_t out_result;
   sdf_result_t got[$];
   int stamp[$];
   int cyc = 0;
   int error_cnt = 0;
   int compares = 0;
   int fs = NOTCH_CODE_MIN * NOTCH_CODE_MIN * NOTCH_CODE_MIN;

   sdf_filter sdf_filter_i (.CLK(clk), .RESET(reset), .MOD_BIT(mod_bit), .CONFIG(cfg),
      .OUT_READY(out_ready), .MOD_TICK(mod_tick), .SAMPLE_STROBE(sample_strobe),
      .CAP_RATIO(cap_ratio), .OUT_RESULT(out_result), .OUT_STROBE(out_strobe),
      .FIFO_FULL(fifo_full), .RESULT_LOST(result_lost));
   sdf_mod_model sdf_mod_model_i (.clk(clk), .level(level), .mod_tick(mod_tick),
      .mod_bit(mod_bit));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (out_strobe === 1'b1) begin
         got.push_back(out_result);
         stamp.push_back(cyc);
      end
   end
   ////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   task automatic gap(input bit samp, output int n);
      n = 0;
      do @(posedge clk); while ((samp ? sample_strobe : mod_tick) !== 1'b1);
      do begin
         @(posedge clk);
         n++;
      end while ((samp ? sample_strobe : mod_tick) !== 1'b1);
   endtask : gap

   task automatic wait_words(input int k);
      while (got.size() < k) @(posedge clk);
   endtask : wait_words

   task automatic zeros;
      check("reset outputs", {mod_tick, sample_strobe, out_strobe, fifo_full, result_lost,
         cap_ratio, out_result}, 0);
   endtask : zeros
   ////////////////////////////////////////
   task automatic t_rates;
      int n;
      for (int g = 0; g < 8; g++) begin
         cfg.gain_code <= 3'(g);
         repeat (300) @(posedge clk);
         gap(1'b1, n);
         check("sample gap", n, g > 2 ? SAMP_DIV / MAX_OVERSAMPLE : SAMP_DIV >> g);
         check("cap ratio", cap_ratio, g);
         gap(1'b0, n);
         check("tick gap", n, MOD_DIV);
      end
   endtask : t_rates

   task automatic t_settle;
      int b;
      // Restart settling just after a word, so no result is in flight
      wait_words(got.size() + 1);
      b = got.size();
      cfg.channel <= ~cfg.channel;
      wait_words(b + 6);
      for (int i = 0; i < 6; i++) begin
         check("settled", got[b+i].settled, i > 3);
      end
      check("full scale", got[b+4].word, fs);
      check("spacing", stamp[b+5] - stamp[b+4], NOTCH_CODE_MIN * MOD_DIV);
      repeat (100) @(posedge clk);
      check("reread", out_result, got[b+5]);
      level <= 1'b0;
      wait_words(b + 10);
      check("negative scale", got[b+9].word, -fs);
   endtask : t_settle

   task automatic t_backpressure;
      int n = 0;
      int b = got.size();
      out_ready <= 1'b0;
      cfg.channel <= ~cfg.channel;
      while (result_lost !== 1'b1 && n < 200000) begin
         @(posedge clk);
         n++;
      end
      check("full", fifo_full, 1'b1);
      check("lost", result_lost, 1'b1);
      check("held", got.size(), b);
      out_ready <= 1'b1;
      repeat (60) @(posedge clk);
      check("drained", got.size(), b + 8);
      for (int i = 0; i < 8; i++) begin
         check("settled", got[b+i].settled, i > 3);
         check("word", got[b+i].word, -fs);
      end
      check("full", fifo_full, 1'b0);
      check("lost", result_lost, 1'b1);
   endtask : t_backpressure

   task automatic t_rereset;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      zeros();
      reset <= 1'b0;
      repeat (1100) @(posedge clk);
   endtask : t_rereset

   initial begin
      reset = 1'b1;
      level = 1'b1;
      out_ready = 1'b1;
      cfg = '{notch_code: NOTCH_CODE_MIN, gain_code: 3'h0, channel: 1'b0};
      repeat (5) @(posedge clk);
      zeros();
      reset <= 1'b0;
      t_rates();
      t_settle();
      t_backpressure();
      t_rereset();
      print_verdict();
   end
   initial begin
      // About thirty-one output periods of the fastest code, with margin
      repeat (300000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end
endmodule : tb_top
